// File: periph_model.sv
// partner model: peripheral outputs and package pin levels
`timescale 1ns/1ps
module periph_model (
	// clock and control
	input  wire logic        clk,
	input  wire logic        hold,
	// peripheral outputs
	output logic      [3:0]  timer_out,
	output logic      [2:0]  hall_phase_out,
	output logic      [5:0]  gate_drive,
	output logic             serial_tx,
	output logic             serial_rxtx_out,
	output logic             serial_rxtx_oe_n,
	// package pin levels
	output logic      [29:0] pin_in
);
	initial begin
		{timer_out, hall_phase_out, gate_drive} = 13'h0000;
		{serial_tx, serial_rxtx_out, serial_rxtx_oe_n} = 3'h1;
		pin_in = 30'h00000000;
	end
	// fresh levels every cycle unless frozen
	always @(posedge clk) begin
		if (!hold) begin
			{timer_out, hall_phase_out, gate_drive} <= 13'($urandom);
			{serial_tx, serial_rxtx_out, serial_rxtx_oe_n} <= 3'($urandom);
			pin_in <= 30'($urandom);
		end
	end
endmodule : periph_model

// File: pin_function_selector.sv
// pin function multiplexer: per-pin function decode, input routing, register slave
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module pin_function_selector (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// package pins
	input  wire logic [`PIN_COUNT-1:0]    pin_in,
	output logic      [`PIN_COUNT-1:0]    pin_out,
	output logic      [`PIN_COUNT-1:0]    pin_oe_n,
	output logic      [`PIN_COUNT-1:0]    pin_analog_en,
	// general purpose io
	input  wire logic [`PIN_COUNT-1:0]    gpio_out,
	input  wire logic [`PIN_COUNT-1:0]    gpio_oe_n,
	output logic      [`PIN_COUNT-1:0]    gpio_in,
	// peripheral outputs
	input  wire logic [3:0]               timer_out,
	input  wire logic [2:0]               hall_phase_out,
	input  wire logic [5:0]               gate_drive,
	input  wire logic                     serial_tx,
	input  wire logic                     serial_rxtx_out,
	input  wire logic                     serial_rxtx_oe_n,
	// routed peripheral inputs
	output logic      [2:0]               hall_sense,
	output logic                          capture_timer_input,
	output logic                          comp_minus_short
);
	import pin_mux_pkg::*;

	logic [`SEL_BITS-1:0]  sel_q;
	logic [`SEL_BITS-1:0]  sel_d;
	byte_t                 isrc_q;
	byte_t                 isrc_d;
	byte_t                 status;
	logic [`PIN_COUNT-1:0] meta_q;
	logic [`PIN_COUNT-1:0] sync_q;
	logic [`PIN_COUNT-1:0] pin_out_d;
	logic [`PIN_COUNT-1:0] pin_oe_n_d;
	logic [`PIN_COUNT-1:0] analog_d;
	logic [2:0]            hall_d;
	logic                  capt_d;
	logic                  short_d;
	func_t                 fn;

	function automatic func_t pick(input code_t c, input func_t f0, input func_t f1,
		input func_t f2, input func_t f3);
		case (c)
			2'h0: pick = f0;
			2'h1: pick = f1;
			2'h2: pick = f2;
			default: pick = f3;
		endcase
	endfunction : pick

	// pins 0..7 port A, 8..15 port B, 16..21 port C, 22..29 port D
	function automatic func_t pin_func(input int idx, input code_t c);
		case (idx)
			// port A lines 0 and 1
			0: pin_func = pick(c, fn_gpio, fn_t0, fn_analog, fn_gpio);
			1: pin_func = pick(c, fn_gpio, fn_analog, fn_gpio, fn_analog);
			// port A lines 2 and 3
			2: pin_func = pick(c, fn_gpio, fn_t1, fn_gpio, fn_gpio);
			3: pin_func = pick(c, fn_gpio, fn_analog, fn_analog, fn_gpio);
			// port A lines 4 and 5
			4: pin_func = pick(c, fn_gpio, fn_analog, fn_analog, fn_gpio);
			5: pin_func = pick(c, fn_gpio, fn_analog, fn_analog, fn_gpio);
			6: pin_func = pick(c, fn_gpio, fn_analog, fn_t2, fn_hb);
			7: pin_func = pick(c, fn_gpio, fn_analog, fn_t0, fn_t0n);
			8: pin_func = pick(c, fn_gpio, fn_analog, fn_hc, fn_t1);
			9: pin_func = pick(c, fn_gpio, fn_analog, fn_analog, fn_analog);
			10: pin_func = pick(c, fn_gpio, fn_analog, fn_analog, fn_t3);
			11: pin_func = pick(c, fn_gpio, fn_analog, fn_t0, fn_t0n);
			// port B lines 4 and 5
			12: pin_func = pick(c, fn_gpio, fn_t0, fn_rxtx, fn_gpio);
			13: pin_func = pick(c, fn_gpio, fn_t0, fn_ha, fn_tx);
			// port B lines 6 and 7
			14: pin_func = pick(c, fn_gpio, fn_t3, fn_t3n, fn_analog);
			15: pin_func = pick(c, fn_gpio, fn_t2, fn_t2n, fn_gpio);
			// port C lines 0 and 1
			16: pin_func = pick(c, fn_gpio, fn_gah, fn_gcl, fn_gbl);
			17: pin_func = pick(c, fn_gpio, fn_gal, fn_gch, fn_gcl);
			// port C lines 2 and 3
			18: pin_func = pick(c, fn_gpio, fn_gbh, fn_gbl, fn_gal);
			19: pin_func = pick(c, fn_gpio, fn_gbl, fn_gbh, fn_gal);
			// port C lines 4 and 5
			20: pin_func = pick(c, fn_gpio, fn_gch, fn_gal, fn_gcl);
			21: pin_func = pick(c, fn_gpio, fn_gcl, fn_gah, fn_gbl);
			// port D lines 0 and 1
			22: pin_func = pick(c, fn_gpio, fn_t0n, fn_t0, fn_tx);
			23: pin_func = pick(c, fn_gpio, fn_t0, fn_hc, fn_rxtx);
			// port D lines 2 and 3
			24: pin_func = pick(c, fn_gpio, fn_t1n, fn_hb, fn_gah);
			25: pin_func = pick(c, fn_gpio, fn_t1, fn_ha, fn_gal);
			// port D lines 4 and 5
			26: pin_func = pick(c, fn_gpio, fn_t2n, fn_t1, fn_gbh);
			27: pin_func = pick(c, fn_gpio, fn_t2, fn_t1n, fn_gbl);
			// port D lines 6 and 7
			28: pin_func = pick(c, fn_gpio, fn_t3n, fn_t0, fn_gch);
			29: pin_func = pick(c, fn_gpio, fn_t3, fn_t0n, fn_gcl);
			default: pin_func = fn_gpio;
		endcase
	endfunction : pin_func

	function automatic logic route(input code_t c, input logic [`PIN_COUNT-1:0] s,
		input int i0, input int i1, input int i2, input int i3);
		case (c)
			2'h0: route = s[i0];
			2'h1: route = s[i1];
			2'h2: route = s[i2];
			default: route = s[i3];
		endcase
	endfunction : route

	sel_regs u_regs (
		.clk      (clk),
		.srst     (srst),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.status   (status),
		.sel_q    (sel_q),
		.sel_d    (sel_d),
		.isrc_q   (isrc_q),
		.isrc_d   (isrc_d)
	);

	assign status = {3'h0, comp_minus_short, capture_timer_input, hall_sense};

	// two-stage pin synchroniser
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	always_comb begin
		fn = fn_gpio;
		pin_out_d = '0;
		pin_oe_n_d = '1;
		analog_d = '0;
		// decode from the next register value
		for (int i = 0; i < `PIN_COUNT; i++) begin
			fn = pin_func(i, sel_d[2*i +: 2]);
			case (fn)
				fn_gpio: begin
					pin_out_d[i] = gpio_out[i];
					pin_oe_n_d[i] = gpio_oe_n[i];
				end
				fn_analog: analog_d[i] = 1'b1;
				fn_t0: pin_out_d[i] = timer_out[0];
				fn_t1: pin_out_d[i] = timer_out[1];
				fn_t2: pin_out_d[i] = timer_out[2];
				fn_t3: pin_out_d[i] = timer_out[3];
				fn_t0n: pin_out_d[i] = ~timer_out[0];
				fn_t1n: pin_out_d[i] = ~timer_out[1];
				fn_t2n: pin_out_d[i] = ~timer_out[2];
				fn_t3n: pin_out_d[i] = ~timer_out[3];
				fn_ha: pin_out_d[i] = hall_phase_out[0];
				fn_hb: pin_out_d[i] = hall_phase_out[1];
				fn_hc: pin_out_d[i] = hall_phase_out[2];
				fn_gah: pin_out_d[i] = gate_drive[0];
				fn_gal: pin_out_d[i] = gate_drive[1];
				fn_gbh: pin_out_d[i] = gate_drive[2];
				fn_gbl: pin_out_d[i] = gate_drive[3];
				fn_gch: pin_out_d[i] = gate_drive[4];
				fn_gcl: pin_out_d[i] = gate_drive[5];
				fn_tx: pin_out_d[i] = serial_tx;
				default: begin
					pin_out_d[i] = serial_rxtx_out;
					pin_oe_n_d[i] = serial_rxtx_oe_n;
				end
			endcase
			if (fn != fn_gpio && fn != fn_analog && fn != fn_rxtx) begin
				pin_oe_n_d[i] = 1'b0;
			end
		end
		short_d = sel_d[`FLD_PORT_B1_LSB +: 2] == `CODE_SHORT_MINUS;
		hall_d[2] = route(isrc_d[`SRC_HALL3_LSB +: 2], sync_q, 5, 9, 13, 5);
		hall_d[1] = route(isrc_d[`SRC_HALL2_LSB +: 2], sync_q, 4, 10, 14, 4);
		hall_d[0] = route(isrc_d[`SRC_HALL1_LSB +: 2], sync_q, 3, 11, 15, 11);
		capt_d = route(isrc_d[`SRC_CAPT_LSB +: 2], sync_q, 6, 12, 22, 28);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out <= '0;
			pin_oe_n <= '1;
			pin_analog_en <= '0;
			gpio_in <= '0;
			hall_sense <= 3'h0;
			capture_timer_input <= 1'b0;
			comp_minus_short <= 1'b0;
		end else begin
			pin_out <= pin_out_d;
			pin_oe_n <= pin_oe_n_d;
			pin_analog_en <= analog_d;
			gpio_in <= sync_q;
			hall_sense <= hall_d;
			capture_timer_input <= capt_d;
			comp_minus_short <= short_d;
		end
	end

	reset_clear_a: assert property (@(posedge clk)
		srst |=> (sel_q == '0 && isrc_q == 8'h00 && pin_oe_n == '1 && pin_analog_en == '0))
		else $error("selection not cleared by reset");

	minus_short_a: assert property (@(posedge clk) disable iff (srst)
		(comp_minus_short == (sel_q[19:18] == 2'h2)) and (comp_minus_short |-> (pin_analog_en[9] && pin_oe_n[9])))
		else $error("comparator short flag disagrees with port B line 1 field");

	a3_analog_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[7:6] == 2'h1 || sel_q[7:6] == 2'h2) |-> (pin_analog_en[3] && pin_oe_n[3]))
		else $error("port A line 3 analog function not released");

	a2_timer_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[5:4] == 2'h1 && $past(sel_q[5:4]) == 2'h1) |-> (!pin_oe_n[2] && pin_out[2] == $past(timer_out[1])))
		else $error("port A line 2 does not carry timer 1 output");

	a7_invert_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[15:14] == 2'h3 && $past(sel_q[15:14]) == 2'h3) |-> (!pin_oe_n[7] && pin_out[7] != $past(timer_out[0])))
		else $error("port A line 7 not inverted timer 0 output");

	b0_hall_out_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[17:16] == 2'h2 && $past(sel_q[17:16]) == 2'h2) |-> pin_out[8] == $past(hall_phase_out[2]))
		else $error("port B line 0 not hall phase c output");

	c3_gate_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[39:38] == 2'h1 && $past(sel_q[39:38]) == 2'h1) |-> (!pin_oe_n[19] && pin_out[19] == $past(gate_drive[3])))
		else $error("port C line 3 not gate phase b low");

	d0_serial_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[45:44] == 2'h3 && $past(sel_q[45:44]) == 2'h3) |-> pin_out[22] == $past(serial_tx))
		else $error("port D line 0 not serial transmit");

	gpio_pass_a: assert property (@(posedge clk) disable iff (srst)
		(sel_q[1:0] == 2'h0 && $past(sel_q[1:0]) == 2'h0) |-> (pin_oe_n[0] == $past(gpio_oe_n[0]) && pin_out[0] == $past(gpio_out[0])))
		else $error("port A line 0 io path not following next cycle");

	hall3_route_a: assert property (@(posedge clk) disable iff (srst)
		(isrc_q[7:6] == 2'h1 && $past(isrc_q[7:6]) == 2'h1) |-> hall_sense[2] == $past(sync_q[9]))
		else $error("hall sense 3 not taken from port B line 1");

	capture_route_a: assert property (@(posedge clk) disable iff (srst)
		(isrc_q[1:0] == 2'h3 && $past(isrc_q[1:0]) == 2'h3) |-> capture_timer_input == $past(sync_q[28]))
		else $error("capture input not taken from port D line 6");
endmodule : pin_function_selector

// File: pin_function_selector_tb.sv
// self-checking bench for the pin function selector
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module pin_function_selector_tb;
	import pin_mux_pkg::*;
	logic                   clk = 1'b0;
	logic                   srst = 1'b1;
	logic                   hold = 1'b1;
	logic                   wb_cyc = 1'b0;
	logic                   wb_stb = 1'b0;
	logic                   wb_we = 1'b0;
	logic [7:0]             wb_adr = 8'h00;
	logic [3:0]             wb_sel = 4'h0;
	logic [31:0]            wb_dat = 32'h00000000;
	logic [31:0]            wb_dat_o;
	logic                   wb_ack_o;
	logic [`PIN_COUNT-1:0]  pin_in, pin_out, pin_oe_n, pin_analog_en, gpio_in;
	logic [`PIN_COUNT-1:0]  gpio_out = 30'h00000000;
	logic [`PIN_COUNT-1:0]  gpio_oe_n = 30'h3FFFFFFF;
	logic [3:0]             timer_out;
	logic [2:0]             hall_phase_out, hall_sense;
	logic [5:0]             gate_drive;
	logic                   serial_tx, serial_rxtx_out, serial_rxtx_oe_n;
	logic                   capture_timer_input, comp_minus_short;
	byte_t                  shadow [9] = '{default: 8'h00};
	logic [31:0]            exp_q [$];
	int                     error_cnt = 0;
	int                     n_checks = 0;
	int                     cyc_cnt = 0;
	// per pin, codes 00..11: g io, A analog, 0-3 timer, 4-7 inverted timer, a-c hall, h-m gate, t tx, r rx/tx
	string fn_tbl = {"g0AggAgAg1gggAAggAAggAAggA2bgA04", "gAc1gAAAgAA3gA04g0rgg0atg37Ag26g",
		"ghmkgilmgjkigkjiglimgmhk", "g40tg0crg5bhg1aig61jg25kg70lg34m"};
	// source pins: hall 1, hall 2, hall 3, capture
	int src [4][4] = '{'{3, 11, 15, 11}, '{4, 10, 14, 4}, '{5, 9, 13, 5}, '{6, 12, 22, 28}};

	always #2.5 clk = ~clk;

	pin_function_selector DUT (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_analog_en(pin_analog_en),
		.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .timer_out(timer_out),
		.hall_phase_out(hall_phase_out), .gate_drive(gate_drive), .serial_tx(serial_tx),
		.serial_rxtx_out(serial_rxtx_out), .serial_rxtx_oe_n(serial_rxtx_oe_n), .hall_sense(hall_sense),
		.capture_timer_input(capture_timer_input), .comp_minus_short(comp_minus_short));

	periph_model u_periph (.clk(clk), .hold(hold), .timer_out(timer_out), .hall_phase_out(hall_phase_out),
		.gate_drive(gate_drive), .serial_tx(serial_tx), .serial_rxtx_out(serial_rxtx_out),
		.serial_rxtx_oe_n(serial_rxtx_oe_n), .pin_in(pin_in));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// one classic cycle, held until ack is sampled
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		wb_sel <= sel;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb_xfer

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_q.push_back(exp);
		wb_xfer(1'b0, adr, 32'h00000000, 4'hF);
	endtask : rd

	task automatic check_pins();
		int r;
		logic [1:0] c;
		byte ch;
		logic eo, en, ea;
		for (int i = 0; i < `PIN_COUNT; i++) begin
			r = (i < 22) ? i / 4 : 6 + (i - 22) / 4;
			c = 2'(shadow[r] >> (2 * ((i < 22) ? i % 4 : (i - 22) % 4)));
			ch = fn_tbl[i * 4 + c];
			{eo, en, ea} = 3'h0;
			case (ch)
				"g": {eo, en} = {gpio_out[i], gpio_oe_n[i]};
				"r": {eo, en} = {serial_rxtx_out, serial_rxtx_oe_n};
				"t": eo = serial_tx;
				"A": {en, ea} = 2'h3;
				default: eo = (ch <= "3") ? timer_out[ch - "0"] : (ch <= "7") ? ~timer_out[ch - "4"] :
					(ch <= "c") ? hall_phase_out[ch - "a"] : gate_drive[ch - "h"];
			endcase
			check(32'({pin_out[i], pin_oe_n[i], pin_analog_en[i]}), 32'({eo, en, ea}));
		end
		check(32'(comp_minus_short), 32'(shadow[2][3:2] == 2'h2));
	endtask : check_pins

	// write, then look at the pins in the very next cycle
	task automatic wr(input int r, input byte_t v);
		wb_xfer(1'b1, 8'(r * 4), {24'h000000, v}, 4'hF);
		shadow[r] = (r == 5) ? (v & 8'h0F) : v;
		#1;
		check_pins();
	endtask : wr

	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
			check(wb_dat_o, exp_q.pop_front());
	end

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			end_of_test();
		end
	end

	initial begin
		logic [2:0] ex;
		logic cap;
		void'($urandom(32'h8f7d));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int r = 0; r < 9; r++)
			rd(8'(r * 4), 32'h00000000);
		#1;
		check_pins();
		// peripherals stay frozen while selections change
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			hold <= 1'b0;
			gpio_out <= 30'($urandom);
			gpio_oe_n <= 30'($urandom);
			@(posedge clk);
			hold <= 1'b1;
			for (int r = 0; r < 8; r++)
				wr(r, 8'(c * 8'h55));
		end
		repeat (24) wr($urandom % 9, 8'($urandom));
		wr(5, 8'hFF);
		for (int r = 0; r < 9; r++)
			rd(8'(r * 4), {24'h000000, shadow[r]});
		wb_xfer(1'b1, 8'h00, 32'h000000A5, 4'h0);
		rd(8'h00, {24'h000000, shadow[0]});
		wb_xfer(1'b1, 8'h30, 32'h000000FF, 4'hF);
		rd(8'h30, 32'h00000000);
		for (int k = 0; k < 8; k++) begin
			wr(8, (k < 4) ? 8'(k * 8'h55) : 8'($urandom));
			@(posedge clk);
			hold <= 1'b0;
			@(posedge clk);
			hold <= 1'b1;
			repeat (4) @(posedge clk);
			#1;
			ex = {pin_in[src[2][shadow[8][7:6]]], pin_in[src[1][shadow[8][5:4]]], pin_in[src[0][shadow[8][3:2]]]};
			cap = pin_in[src[3][shadow[8][1:0]]];
			check(32'(hall_sense), 32'(ex));
			check(32'(capture_timer_input), 32'(cap));
			check(32'(gpio_in), 32'(pin_in));
			rd(8'h24, 32'({shadow[2][3:2] == 2'h2, cap, ex}));
		end
		repeat (3) @(posedge clk);
		end_of_test();
	end
endmodule : pin_function_selector_tb

// File: pin_mux_consts.svh
// register map, field positions and reset values of the pin function selector
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define OFS_PORT_A_SEL_0   8'h00
`define OFS_PORT_A_SEL_1   8'h04
`define OFS_PORT_B_SEL_0   8'h08
`define OFS_PORT_B_SEL_1   8'h0C
`define OFS_PORT_C_SEL_0   8'h10
`define OFS_PORT_C_SEL_1   8'h14
`define OFS_PORT_D_SEL_0   8'h18
`define OFS_PORT_D_SEL_1   8'h1C
`define OFS_INPUT_SRC_0    8'h20
`define OFS_STATUS         8'h24

`define IDX_PORT_C_SEL_1   4'h5
`define IDX_INPUT_SRC_0    4'h8
`define IDX_STATUS         4'h9
`define IDX_NONE           4'hF

`define SEL_RESET          8'h00
`define PORT_C_SEL_1_MASK  8'h0F
`define SEL_BITS           60
`define PIN_COUNT          30

`define SRC_HALL3_LSB      6
`define SRC_HALL2_LSB      4
`define SRC_HALL1_LSB      2
`define SRC_CAPT_LSB       0
`define FLD_PORT_B1_LSB    18
`define CODE_SHORT_MINUS   2'h2

`endif

// File: pin_mux_pkg.sv
// types shared by the pin function selector files
package pin_mux_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] code_t;
	typedef enum {
		fn_gpio, fn_analog,
		fn_t0, fn_t1, fn_t2, fn_t3,
		fn_t0n, fn_t1n, fn_t2n, fn_t3n,
		fn_ha, fn_hb, fn_hc,
		fn_gah, fn_gal, fn_gbh, fn_gbl, fn_gch, fn_gcl,
		fn_tx, fn_rxtx
	} func_t;
endpackage : pin_mux_pkg

// File: sel_regs.sv
// wishbone slave holding the selection and input source registers
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module sel_regs (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	// register contents
	input  wire pin_mux_pkg::byte_t      status,
	output logic      [`SEL_BITS-1:0]    sel_q,
	output logic      [`SEL_BITS-1:0]    sel_d,
	output pin_mux_pkg::byte_t           isrc_q,
	output pin_mux_pkg::byte_t           isrc_d
);
	import pin_mux_pkg::*;

	byte_t       regs_q [0:8];
	byte_t       regs_d [0:8];
	logic [31:0] dat_d;
	logic        ack_d;
	logic        wr;

	function automatic logic [3:0] reg_index(input logic [7:0] adr);
		if (adr == `OFS_PORT_A_SEL_0) reg_index = 4'h0;
		else if (adr == `OFS_PORT_A_SEL_1) reg_index = 4'h1;
		else if (adr == `OFS_PORT_B_SEL_0) reg_index = 4'h2;
		else if (adr == `OFS_PORT_B_SEL_1) reg_index = 4'h3;
		else if (adr == `OFS_PORT_C_SEL_0) reg_index = 4'h4;
		else if (adr == `OFS_PORT_C_SEL_1) reg_index = `IDX_PORT_C_SEL_1;
		else if (adr == `OFS_PORT_D_SEL_0) reg_index = 4'h6;
		else if (adr == `OFS_PORT_D_SEL_1) reg_index = 4'h7;
		else if (adr == `OFS_INPUT_SRC_0) reg_index = `IDX_INPUT_SRC_0;
		else if (adr == `OFS_STATUS) reg_index = `IDX_STATUS;
		else reg_index = `IDX_NONE;
	endfunction : reg_index

	always_comb begin
		// write lands on the edge where the master sees ack
		wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
		ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
		dat_d = wb_dat_o;
		for (int i = 0; i < 9; i++) begin
			regs_d[i] = regs_q[i];
			if (wr && reg_index(wb_adr_i) == i[3:0]) begin
				regs_d[i] = wb_dat_i[7:0];
			end
		end
		regs_d[`IDX_PORT_C_SEL_1] = regs_d[`IDX_PORT_C_SEL_1] & `PORT_C_SEL_1_MASK;
		if (ack_d) begin
			dat_d = 32'h00000000;
			if (reg_index(wb_adr_i) == `IDX_STATUS) begin
				dat_d[7:0] = status;
			end else if (reg_index(wb_adr_i) != `IDX_NONE) begin
				dat_d[7:0] = regs_q[reg_index(wb_adr_i)];
			end
		end
		sel_d = {regs_d[7], regs_d[6], regs_d[5][3:0], regs_d[4], regs_d[3], regs_d[2], regs_d[1], regs_d[0]};
		isrc_d = regs_d[8];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < 9; i++) begin
				regs_q[i] <= `SEL_RESET;
			end
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			for (int i = 0; i < 9; i++) begin
				regs_q[i] <= regs_d[i];
			end
			wb_ack_o <= ack_d;
			wb_dat_o <= dat_d;
		end
	end

	assign sel_q = {regs_q[7], regs_q[6], regs_q[5][3:0], regs_q[4], regs_q[3], regs_q[2], regs_q[1], regs_q[0]};
	assign isrc_q = regs_q[8];

	c_sel1_zero_a: assert property (@(posedge clk) disable iff (srst)
		(wb_ack_o && $past(reg_index(wb_adr_i)) == `IDX_PORT_C_SEL_1) |-> wb_dat_o[31:4] == 28'h0000000)
		else $error("unimplemented selection bits read nonzero");
endmodule : sel_regs
